//--- inc/hpcr_map.svh
`ifndef HPCR_MAP_SVH
`define HPCR_MAP_SVH

// Register offsets within the hub configuration space
`define HPCR_OFS_CHARGE 8'h06
`define HPCR_OFS_REMOVABLE 8'h07
`define HPCR_OFS_USED 8'h08

// Field positions
`define HPCR_FIELD_MSB 3
`define HPCR_FIELD_LSB 0
`define HPCR_UNLOCK_BIT 7

// Reset values
`define HPCR_RST_CHARGE 4'h0
`define HPCR_RST_REMOVABLE 4'h0
`define HPCR_RST_USED 4'hf
`define HPCR_RST_LEGACY 4'h0
`define HPCR_RST_RDATA 8'h00

// Read value of reserved bits; unmapped offsets read HPCR_RST_RDATA
`define HPCR_RSVD_ZERO4 4'h0
`define HPCR_RSVD_ZERO3 3'h0

`endif

//--- inc/hpcr_pkg.sv
package hpcr_pkg;

   // One bit per downstream port, bit 0 is port 1
   typedef logic [3:0] hpcr_port_mask_type;

   // Strap capture sequence after reset release
   typedef enum logic [1:0] {
      HPCR_CAP_FILL1,
      HPCR_CAP_FILL2,
      HPCR_CAP_LOAD,
      HPCR_CAP_DONE
   } hpcr_cap_state_type;

endpackage

//--- rtl/hpcr_strap_capture.sv
`timescale 1ns/1ns
`default_nettype none

module hpcr_strap_capture #(
   parameter int WIDTH = 4
) (
   input wire logic i_mclk, // System clock
   input wire logic i_sys_rst, // Async reset, active high
   input wire logic [WIDTH-1:0] i_pins, // Raw strap pins
   output logic [WIDTH-1:0] o_sync, // Synchronised strap levels
   output logic o_capture // One-cycle load strobe
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;
   hpcr_pkg::hpcr_cap_state_type state_q;

   // Two-stage synchroniser per pin; first stage feeds only the second
   for (genvar g = 0; g < WIDTH; g++) begin : g_sync
      always_ff @(posedge i_mclk or posedge i_sys_rst) begin
         if (i_sys_rst) begin
            meta_q[g] <= 1'b0;
            sync_q[g] <= 1'b0;
         end else begin
            meta_q[g] <= i_pins[g];
            sync_q[g] <= meta_q[g];
         end
      end
   end

   // Wait for the synchroniser to fill, then load once
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_q <= hpcr_pkg::HPCR_CAP_FILL1;
      end else begin
         case (state_q)
            hpcr_pkg::HPCR_CAP_FILL1: state_q <= hpcr_pkg::HPCR_CAP_FILL2;
            hpcr_pkg::HPCR_CAP_FILL2: state_q <= hpcr_pkg::HPCR_CAP_LOAD;
            hpcr_pkg::HPCR_CAP_LOAD: state_q <= hpcr_pkg::HPCR_CAP_DONE;
            default: state_q <= hpcr_pkg::HPCR_CAP_DONE;
         endcase
      end
   end

   assign o_sync = sync_q;
   assign o_capture = (state_q == hpcr_pkg::HPCR_CAP_LOAD);

   // Exactly one strobe per reset release
   a_single_load: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      o_capture |=> !o_capture [*8])
      else $error("strap load strobe repeated");

endmodule

`default_nettype wire

//--- rtl/hpcr_lock_field.sv
`timescale 1ns/1ns
`default_nettype none

module hpcr_lock_field #(
   parameter int WIDTH = 4,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic i_mclk, // System clock
   input wire logic i_sys_rst, // Async reset, active high
   input wire logic i_lock, // Field follows OTP while high
   input wire logic i_we, // Accepted write strobe
   input wire logic [WIDTH-1:0] i_wdata, // Write data
   input wire logic [WIDTH-1:0] i_otp, // OTP-derived value
   output logic [WIDTH-1:0] o_value // Current field value
);

   logic [WIDTH-1:0] value_q;
   logic [WIDTH-1:0] value_d;

   // Write beats OTP tracking so an unlocking write lands at once
   always_comb begin
      value_d = value_q;
      if (i_we) begin
         value_d = i_wdata;
      end else if (i_lock) begin
         value_d = i_otp;
      end
   end

   // Tracking OTP while locked means unlocking starts from a sane value
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         value_q <= RST_VAL;
      end else begin
         value_q <= value_d;
      end
   end

   assign o_value = value_q;

   a_write_lands: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      i_we |=> o_value == $past(i_wdata))
      else $error("accepted field write not stored");

   a_locked_follow: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (i_lock && !i_we) |=> o_value == $past(i_otp))
      else $error("locked field does not follow OTP");

endmodule

`default_nettype wire

//--- rtl/hpcr_port_config.sv
// Overview of operation
// - Reserved bits 7:4 at 0x6 and 6:4 at 0x7 read zero.
// - charge_port_enable bit n enables charging features on port n+1.
// - Strap pins load charge_port_enable once after reset release.
// - In serial mode, EEPROM load or SMBus may rewrite charge_port_enable.
// - Unlock low: removable, used, legacy fields read-only from OTP.
// - One write may set unlock and new removable value together.
// - port_removable bit n: port n+1 device removable (1) or fixed.
// - Locked port_removable reads as inverse of OTP fixed-device bits.
// - port_in_use bit n marks port n+1 used; resets to all ones.
// - port_in_use is read-only unless unlock is set.
// - legacy_speed_only keeps the port's USB 2.0 side in use.
`timescale 1ns/1ns
`default_nettype none
`include "hpcr_map.svh"

module hpcr_port_config #(
   parameter int PORTS = 4
) (
   input wire logic i_mclk, // 20 MHz system clock
   input wire logic i_sys_rst, // Async reset, active high
   input wire logic i_serial_mode, // EEPROM/SMBus configuration mode
   input wire logic i_cfg_wr, // Register write strobe
   input wire logic i_cfg_rd, // Register read strobe
   input wire logic [7:0] i_cfg_addr, // Register offset
   input wire logic [7:0] i_cfg_wdata, // Write data
   input wire logic i_legacy_wr, // legacy_speed_only write strobe
   input wire logic [PORTS-1:0] i_legacy_wdata, // legacy_speed_only data
   input wire logic [PORTS-1:0] i_power_charge_pins, // Charge strap pins
   input wire logic [PORTS-1:0] i_otp_fixed_device, // OTP fixed flags
   input wire logic [PORTS-1:0] i_otp_port_used, // OTP port used
   input wire logic [PORTS-1:0] i_otp_legacy_only, // OTP legacy speed
   output logic [7:0] o_cfg_rdata, // Read data, registered
   output logic o_cfg_rvalid, // Read data valid pulse
   output logic o_cfg_hit, // Last read hit this block
   output logic o_custom_removable_unlock, // Unlock bit
   output logic [PORTS-1:0] o_charge_port_enable, // Charging enables
   output logic [PORTS-1:0] o_port_removable, // Removable flags
   output logic [PORTS-1:0] o_port_in_use, // Port used flags
   output logic [PORTS-1:0] o_legacy_speed_only, // USB 2.0 only flags
   output logic [PORTS-1:0] o_usb2_port_used // Effective USB 2.0 use
);

   logic [PORTS-1:0] strap_sync;
   logic strap_load;
   logic [PORTS-1:0] charge_q;
   logic unlock_q;
   logic [PORTS-1:0] removable;
   logic [PORTS-1:0] in_use;
   logic [PORTS-1:0] legacy;
   logic sel_charge;
   logic sel_removable;
   logic sel_used;
   logic charge_we;
   logic removable_we;
   logic used_we;
   logic legacy_we;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic rvalid_q;
   logic hit_q;
   logic hit_d;

   // Strap sampling runs through its own synchroniser
   hpcr_strap_capture #(
      .WIDTH(PORTS)
   ) u_strap (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_pins(i_power_charge_pins),
      .o_sync(strap_sync),
      .o_capture(strap_load)
   );

   // Offset decode
   assign sel_charge = (i_cfg_addr == `HPCR_OFS_CHARGE);
   assign sel_removable = (i_cfg_addr == `HPCR_OFS_REMOVABLE);
   assign sel_used = (i_cfg_addr == `HPCR_OFS_USED);

   // Write qualification per field
   assign charge_we = i_cfg_wr && sel_charge && i_serial_mode;
   // Incoming unlock bit counts, so one write can unlock and update
   assign removable_we = i_cfg_wr && sel_removable &&
      (unlock_q || i_cfg_wdata[`HPCR_UNLOCK_BIT]);
   assign used_we = i_cfg_wr && sel_used && unlock_q;
   assign legacy_we = i_legacy_wr && unlock_q;

   // Charging enables: strap load wins over a write in the same cycle
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         charge_q <= `HPCR_RST_CHARGE;
      end else if (strap_load) begin
         charge_q <= strap_sync;
      end else if (charge_we) begin
         charge_q <= i_cfg_wdata[`HPCR_FIELD_MSB:`HPCR_FIELD_LSB];
      end
   end

   // Unlock bit is plain read/write
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         unlock_q <= 1'b0;
      end else if (i_cfg_wr && sel_removable) begin
         unlock_q <= i_cfg_wdata[`HPCR_UNLOCK_BIT];
      end
   end

   // Removable flags; locked value is the inverted OTP fixed mask
   hpcr_lock_field #(
      .WIDTH(PORTS),
      .RST_VAL(`HPCR_RST_REMOVABLE)
   ) u_removable (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_lock(!unlock_q),
      .i_we(removable_we),
      .i_wdata(i_cfg_wdata[`HPCR_FIELD_MSB:`HPCR_FIELD_LSB]),
      .i_otp(~i_otp_fixed_device),
      .o_value(removable)
   );

   // Port used flags, all ports used out of reset
   hpcr_lock_field #(
      .WIDTH(PORTS),
      .RST_VAL(`HPCR_RST_USED)
   ) u_used (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_lock(!unlock_q),
      .i_we(used_we),
      .i_wdata(i_cfg_wdata[`HPCR_FIELD_MSB:`HPCR_FIELD_LSB]),
      .i_otp(i_otp_port_used),
      .o_value(in_use)
   );

   // USB 2.0-only flags, same unlock gate
   hpcr_lock_field #(
      .WIDTH(PORTS),
      .RST_VAL(`HPCR_RST_LEGACY)
   ) u_legacy (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_lock(!unlock_q),
      .i_we(legacy_we),
      .i_wdata(i_legacy_wdata),
      .i_otp(i_otp_legacy_only),
      .o_value(legacy)
   );

   // Read mux; reserved bits and foreign offsets return zero
   always_comb begin
      rdata_d = `HPCR_RST_RDATA;
      hit_d = 1'b0;
      if (sel_charge) begin
         rdata_d = {`HPCR_RSVD_ZERO4, charge_q};
         hit_d = 1'b1;
      end else if (sel_removable) begin
         rdata_d = {unlock_q, `HPCR_RSVD_ZERO3, removable};
         hit_d = 1'b1;
      end else if (sel_used) begin
         rdata_d = {`HPCR_RSVD_ZERO4, in_use};
         hit_d = 1'b1;
      end
   end

   // Read data held until the next read
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rdata_q <= `HPCR_RST_RDATA;
         hit_q <= 1'b0;
      end else if (i_cfg_rd) begin
         rdata_q <= rdata_d;
         hit_q <= hit_d;
      end
   end

   // Read valid strobe
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= i_cfg_rd;
      end
   end

   assign o_cfg_rdata = rdata_q;
   assign o_cfg_rvalid = rvalid_q;
   assign o_cfg_hit = hit_q;
   assign o_custom_removable_unlock = unlock_q;
   assign o_charge_port_enable = charge_q;
   assign o_port_removable = removable;
   assign o_port_in_use = in_use;
   assign o_legacy_speed_only = legacy;
   // Used flag alone cannot switch off a legacy-only port
   assign o_usb2_port_used = in_use | legacy;

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_sys_rst);

   a_charge_rsvd_zero: assert property (
      i_cfg_rd && sel_charge |=> o_cfg_rvalid && o_cfg_rdata[7:4] == 4'h0
      && o_cfg_rdata[3:0] == $past(charge_q))
      else $error("charging register read wrong");

   a_removable_rsvd_zero: assert property (
      i_cfg_rd && sel_removable |=> o_cfg_rdata[6:4] == 3'h0
      && o_cfg_rdata[7] == $past(unlock_q))
      else $error("removable register read wrong");

   a_strap_load: assert property (
      strap_load |=> o_charge_port_enable == $past(strap_sync))
      else $error("strap value not loaded");

   a_charge_serial_write: assert property (
      i_cfg_wr && sel_charge && i_serial_mode && !strap_load
      |=> o_charge_port_enable == $past(i_cfg_wdata[3:0]))
      else $error("serial write to charging enables lost");

   a_charge_nonserial_hold: assert property (
      i_cfg_wr && sel_charge && !i_serial_mode && !strap_load
      |=> $stable(o_charge_port_enable))
      else $error("charging enables changed outside serial mode");

   a_unlock_same_write: assert property (
      i_cfg_wr && sel_removable && i_cfg_wdata[7]
      |=> o_custom_removable_unlock
      && o_port_removable == $past(i_cfg_wdata[3:0]))
      else $error("unlocking write did not apply removable value");

   a_removable_otp_inverse: assert property (
      !unlock_q && !(i_cfg_wr && sel_removable && i_cfg_wdata[7])
      |=> o_port_removable == ~$past(i_otp_fixed_device))
      else $error("locked removable is not inverted OTP");

   a_used_locked: assert property (
      i_cfg_wr && sel_used && !unlock_q
      |=> o_port_in_use == $past(i_otp_port_used))
      else $error("locked port used field was written");

   a_used_unlocked: assert property (
      i_cfg_wr && sel_used && unlock_q
      |=> o_port_in_use == $past(i_cfg_wdata[3:0]))
      else $error("unlocked port used write lost");

   a_legacy_keeps_usb2: assert property (
      i_legacy_wr && unlock_q |=> (o_usb2_port_used & $past(i_legacy_wdata))
      == $past(i_legacy_wdata))
      else $error("legacy port not kept in use");

   a_used_read: assert property (
      i_cfg_rd && sel_used |=> o_cfg_hit
      && o_cfg_rdata == {`HPCR_RSVD_ZERO4, $past(in_use)})
      else $error("port used register read wrong");

   // Locked legacy field must ignore its write strobe entirely
   a_legacy_refused: assert property (
      i_legacy_wr && !unlock_q
      |=> o_legacy_speed_only == $past(i_otp_legacy_only))
      else $error("locked legacy field was written");

   c_strap_load: cover property (strap_load ##1 o_charge_port_enable != 4'h0);
   c_unlock_write: cover property (i_cfg_wr && sel_removable && i_cfg_wdata[7]
      && !unlock_q);
   c_used_write: cover property (used_we ##1 o_port_in_use != 4'hf);
   c_legacy_override: cover property (|(legacy & ~in_use));

endmodule

`default_nettype wire

//--- dv/hpcr_eeprom_model.sv
`timescale 1ns/1ns
`default_nettype none

// Serial configuration memory: replays a three-byte image after a start pulse
module hpcr_eeprom_model (
   input wire logic i_mclk, // System clock
   input wire logic i_sys_rst, // Async reset, active high
   input wire logic i_start, // Begin image load
   output logic o_busy, // Load in progress
   output logic o_wr, // Write strobe toward the block
   output logic [7:0] o_addr, // Register offset
   output logic [7:0] o_wdata // Write data
);
   logic [1:0] step_q;

   // Image: unlock first, so the later used-field write is accepted
   // Ports 1 and 3 are never both disabled in the image
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         step_q <= 2'h0;
         o_busy <= 1'b0;
         o_wr <= 1'b0;
         o_addr <= 8'h00;
         o_wdata <= 8'h00;
      end else if (i_start && !o_busy) begin
         o_busy <= 1'b1;
         step_q <= 2'h0;
      end else if (o_busy) begin
         o_wr <= (step_q != 2'h3);
         o_busy <= (step_q != 2'h3);
         step_q <= step_q + 2'h1;
         case (step_q)
            2'h0: begin
               o_addr <= 8'h07;
               o_wdata <= 8'h81;
            end
            2'h1: begin
               o_addr <= 8'h08;
               o_wdata <= 8'h05;
            end
            2'h2: begin
               o_addr <= 8'h06;
               o_wdata <= 8'h03;
            end
            // Released bus shows a changed pattern, not the last byte
            default: begin
               o_addr <= ~o_addr;
               o_wdata <= ~o_wdata;
            end
         endcase
      end
   end
endmodule

`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, ex, got) \
   samples_checked++; \
   if ((got) !== (ex)) begin \
      $display("[ERR] %s expected %h seen %h", nm, ex, got); \
      bad_count++; \
   end

module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic smode = 1'b0;
   logic tb_wr = 1'b0;
   logic tb_rd = 1'b0;
   logic [7:0] tb_addr = 8'h00;
   logic [7:0] tb_wdata = 8'h00;
   logic lwr = 1'b0;
   logic [3:0] lwdata = 4'h0;
   logic [3:0] pins = 4'hA;
   logic ee_start = 1'b0;
   logic ee_busy, ee_wr;
   logic [7:0] ee_addr, ee_wdata, rdata;
   logic rvalid, hit, unlock;
   logic [3:0] chg, rmbl, used, legacy, usb2;
   int bad_count = 0;
   int samples_checked = 0;

   always #25 clk = ~clk;

   // Memory owns the register port while it loads
   hpcr_eeprom_model hpcr_eeprom_model_inst (
      .i_mclk(clk), .i_sys_rst(rst), .i_start(ee_start), .o_busy(ee_busy),
      .o_wr(ee_wr), .o_addr(ee_addr), .o_wdata(ee_wdata));

   hpcr_port_config #(.PORTS(4)) hpcr_port_config_inst (
      .i_mclk(clk), .i_sys_rst(rst), .i_serial_mode(smode),
      .i_cfg_wr(ee_busy ? ee_wr : tb_wr), .i_cfg_rd(tb_rd),
      .i_cfg_addr(ee_busy ? ee_addr : tb_addr),
      .i_cfg_wdata(ee_busy ? ee_wdata : tb_wdata),
      .i_legacy_wr(lwr), .i_legacy_wdata(lwdata),
      .i_power_charge_pins(pins), .i_otp_fixed_device(4'h3),
      .i_otp_port_used(4'hD), .i_otp_legacy_only(4'h0),
      .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid), .o_cfg_hit(hit),
      .o_custom_removable_unlock(unlock), .o_charge_port_enable(chg),
      .o_port_removable(rmbl), .o_port_in_use(used),
      .o_legacy_speed_only(legacy), .o_usb2_port_used(usb2));

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      tb_wr = 1'b1;
      tb_addr = a;
      tb_wdata = d;
      @(negedge clk);
      tb_wr = 1'b0;
   endtask

   // Read valid stands one cycle, so the answer is sampled at the next falling edge
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic h;
      h = (a >= 8'h06) && (a <= 8'h08);
      @(negedge clk);
      tb_rd = 1'b1;
      tb_addr = a;
      @(negedge clk);
      tb_rd = 1'b0;
      `CHK("read", {h, 1'b1, e}, {hit, rvalid, rdata})
   endtask

   task automatic lw(input logic [3:0] d);
      @(negedge clk);
      lwr = 1'b1;
      lwdata = d;
      @(negedge clk);
      lwr = 1'b0;
   endtask

   task automatic test_done;
      $display("Mismatches %0d, comparisons %0d", bad_count, samples_checked);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      int n;
      repeat (2) @(negedge clk);
      `CHK("used_rst", 4'hF, used)
      rst = 1'b0;
      repeat (5) @(negedge clk);
      rd(8'h06, 8'h0A);
      `CHK("charge", 4'hA, chg)
      rd(8'h07, 8'h0C);
      rd(8'h08, 8'h0D);
      wr(8'h06, 8'hF5);
      rd(8'h06, 8'h0A);
      smode = 1'b1;
      wr(8'h06, 8'hF5);
      rd(8'h06, 8'h05);
      wr(8'h08, 8'h01);
      wr(8'h07, 8'h05);
      lw(4'h5);
      rd(8'h08, 8'h0D);
      rd(8'h07, 8'h0C);
      `CHK("legacy_locked", 4'h0, legacy)
      wr(8'h07, 8'hF6);
      `CHK("unlock", 1'b1, unlock)
      `CHK("rmbl", 4'h6, rmbl)
      rd(8'h07, 8'h86);
      // Port 1 stays enabled so ports 1 and 3 are never both off
      wr(8'h08, 8'hFB);
      rd(8'h08, 8'h0B);
      lw(4'h5);
      `CHK("usb2", 4'hF, usb2)
      rd(8'h09, 8'h00);
      @(negedge clk);
      ee_start = 1'b1;
      @(negedge clk);
      ee_start = 1'b0;
      n = 0;
      while (ee_busy && n < 20) begin
         @(negedge clk);
         n++;
      end
      // A stuck load counts once and the run carries on to the report
      if (n >= 20) begin
         $display("[ERR] eeprom_load expected idle seen busy");
         bad_count++;
      end
      rd(8'h07, 8'h81);
      rd(8'h08, 8'h05);
      rd(8'h06, 8'h03);
      wr(8'h07, 8'h00);
      rd(8'h07, 8'h0C);
      rd(8'h08, 8'h0D);
      `CHK("usb2_relock", 4'hD, usb2)
      // Mid-run reset with new strap levels; charge must reload from pins
      pins = 4'h6;
      rst = 1'b1;
      @(negedge clk);
      `CHK("rst2", 8'h0F, {chg, used})
      rst = 1'b0;
      repeat (5) @(negedge clk);
      rd(8'h06, 8'h06);
      test_done();
   end

   // Hang guard
   initial begin
      repeat (2000) @(posedge clk);
      $display("[ERR] run_time expected finish seen timeout");
      bad_count++;
      test_done();
   end
endmodule

`default_nettype wire
